// [verilog/pwm_generator_control_low_byte.sv]
/*
  one pwm generator with its control register, a directly written period, shadowed duty, dead-time and phase registers,
  dead-time insertion and compensation, and an AHB-Lite slave.
  assumes compensation and current-limit inputs come from pins (synchronised
  here) and the two master time-base ticks are on clk.
*/
`timescale 1ns/10ps
module pwm_generator_control_low_byte
  import pwm_gen_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // time base ticks and pins
  input  wire logic          primaryTick,
  input  wire logic          secondaryTick,
  input  wire logic          compensationPin,
  input  wire logic          currentLimitPin,
  // power stage
  output logic               highSideOut,
  output logic               lowSideOut
);
  // widths outside this range break the status word and the delay counter
  if (W < 4 || W > 16) begin : g_width_chk
    $error("W must be 4..16");
  end

  // reserved control bit and bus decode widths
  localparam int         BIT_RSVD   = 4;
  localparam int         ADDR_BITS  = 8;
  localparam int         CTL_BITS   = 16;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic [15:0]  ctl;
    logic [W-1:0] per, duty, dt, adt, ph;
    logic [W-1:0] sDuty, sDt, sAdt, sPh;
    logic [W-1:0] cnt;
    logic         down;
    logic         rawPwm;
    logic [W-1:0] dly;
    logic         hi, lo;
    logic [1:0]   cmpSync, limSync;
    logic         aPend, aWr;
    logic [7:0]   aAddr;
    logic [31:0]  rdata;
  } state_t;

  state_t s_r, s_nxt;

  function automatic logic [W-1:0] low_bits(input logic [31:0] d);
    return d[W-1:0];
  endfunction : low_bits

  logic          tick, centre, extRst, boundary, cmpIn, limIn, upd;
  logic [1:0]    dtc;
  logic [W-1:0]  riseDly, fallDly;

  always_comb begin
    s_nxt = s_r;
    dtc    = s_r.ctl[BIT_DTC_LO+1 -: 2];
    cmpIn  = s_r.cmpSync[1];
    limIn  = s_r.limSync[1];
    tick   = s_r.ctl[BIT_TIME_BASE_SELECT] ? secondaryTick : primaryTick;
    centre = s_r.ctl[BIT_CAM] && s_r.ctl[BIT_ITB];
    extRst = s_r.ctl[BIT_EXTERNAL_PERIOD_RESET_ENABLE] && s_r.ctl[BIT_ITB] && !s_r.ctl[BIT_CURRENT_LIMIT_MODE] && limIn;
    boundary = tick && (centre ? (s_r.down && s_r.cnt == '0) : (s_r.cnt >= s_r.per));
    s_nxt.cmpSync = {s_r.cmpSync[0], compensationPin};
    s_nxt.limSync = {s_r.limSync[0], currentLimitPin};
    // counter
    if (!s_r.ctl[BIT_ENABLE] || extRst) begin
      s_nxt.cnt  = '0;
      s_nxt.down = 1'b0;
    end else if (tick) begin
      if (centre) begin
        if (!s_r.down && s_r.cnt >= s_r.per) s_nxt.down = 1'b1;
        else if (s_r.down && s_r.cnt == '0) s_nxt.down = 1'b0;
        else s_nxt.cnt = s_r.down ? s_r.cnt - 1'b1 : s_r.cnt + 1'b1;
      end else begin
        s_nxt.cnt  = (s_r.cnt >= s_r.per) ? '0 : s_r.cnt + 1'b1;
        s_nxt.down = 1'b0;
      end
    end
    // phase offset shifts the compare point
    s_nxt.rawPwm = s_r.ctl[BIT_ENABLE] && (s_r.cnt - s_r.ph < s_r.duty);
    // shadow copy, all words in the same cycle
    upd = s_r.ctl[BIT_IUE] || boundary;
    if (upd) begin
      s_nxt.duty = s_r.sDuty;
      s_nxt.dt   = s_r.sDt;
      s_nxt.adt  = s_r.sAdt;
      s_nxt.ph   = s_r.sPh;
    end
    // dead time: rise delay applies to high side, fall delay to low side
    riseDly = s_r.dt;
    fallDly = s_r.adt;
    case (dtc)
      DTC_POS: begin
        riseDly = s_r.dt;
        fallDly = s_r.adt;
      end
      DTC_NEG: begin
        riseDly = '0;
        fallDly = '0;
      end
      DTC_OFF: begin
        riseDly = '0;
        fallDly = '0;
      end
      DTC_COMP: begin
        // true when the high side is the one to shorten
        if (s_r.ctl[BIT_COMPENSATION_POLARITY] ? cmpIn : !cmpIn) begin
          riseDly = s_r.dt;
          fallDly = '0;
        end else begin
          riseDly = '0;
          fallDly = s_r.dt;
        end
      end
      default: begin
        riseDly = '0;
        fallDly = '0;
      end
    endcase
    if (s_nxt.rawPwm != s_r.rawPwm) s_nxt.dly = '0;
    else if (s_r.dly != {W{1'b1}}) s_nxt.dly = s_r.dly + 1'b1;
    if (dtc == DTC_NEG) begin
      // negative dead time: both sides overlap for dt cycles after an edge
      s_nxt.hi = s_r.rawPwm || (s_r.dly < s_r.dt);
      s_nxt.lo = !s_r.rawPwm || (s_r.dly < s_r.dt);
    end else begin
      s_nxt.hi = s_r.rawPwm && (s_r.dly >= riseDly);
      s_nxt.lo = !s_r.rawPwm && (s_r.dly >= fallDly);
    end
    if (!s_r.ctl[BIT_ENABLE]) begin
      s_nxt.hi = 1'b0;
      s_nxt.lo = 1'b0;
    end
    // bus: data phase of the previous address
    if (s_r.aPend && s_r.aWr) begin
      case (s_r.aAddr)
        OFS_CONTROL:  s_nxt.ctl   = hwdata[CTL_BITS-1:0] & CONTROL_WMASK;
        OFS_PERIOD:   s_nxt.per   = low_bits(hwdata);
        OFS_DUTY:     s_nxt.sDuty = low_bits(hwdata);
        OFS_DEADTIME: s_nxt.sDt   = low_bits(hwdata);
        OFS_ALTDEAD:  s_nxt.sAdt  = low_bits(hwdata);
        OFS_PHASE:    s_nxt.sPh   = low_bits(hwdata);
        default: ;
      endcase
    end
    // only whole-word transfers are decoded; narrower ones are dropped
    s_nxt.aPend = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
    s_nxt.aWr   = hwrite;
    s_nxt.aAddr = haddr[ADDR_BITS-1:0];
    s_nxt.rdata = '0;
    if (s_nxt.aPend && !hwrite) begin
      case (haddr[ADDR_BITS-1:0])
        OFS_CONTROL:  s_nxt.rdata = {16'h0000, s_r.ctl};
        OFS_PERIOD:   s_nxt.rdata = 32'(s_r.per);
        OFS_DUTY:     s_nxt.rdata = 32'(s_r.duty);
        OFS_DEADTIME: s_nxt.rdata = 32'(s_r.dt);
        OFS_ALTDEAD:  s_nxt.rdata = 32'(s_r.adt);
        OFS_PHASE:    s_nxt.rdata = 32'(s_r.ph);
        OFS_STATUS:   s_nxt.rdata = {14'h0000, s_r.down, centre, 16'(s_r.cnt)};
        default:      s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // zero wait states: ready and response are fixed levels, not registered
  assign hrdata      = s_r.rdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign highSideOut = s_r.hi;
  assign lowSideOut  = s_r.lo;

  // assertions
  bit_four_zero_a: assert property (@(posedge clk) disable iff (!rst_n) !s_r.ctl[BIT_RSVD])
    else $error("bit 4 set");
  no_overlap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (dtc != DTC_NEG) |-> !(s_r.hi && s_r.lo)) else $error("outputs overlap");
  dead_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (dtc == DTC_OFF && s_r.ctl[BIT_ENABLE] && $stable(s_r.ctl)) |=> (s_r.hi == $past(s_r.rawPwm)))
    else $error("dead time not off");
  edge_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    !s_r.ctl[BIT_ITB] |-> !centre) else $error("centre without itb");
  ext_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.ctl[BIT_CURRENT_LIMIT_MODE] || !s_r.ctl[BIT_ITB]) |-> !extRst) else $error("bad external reset");
  ext_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    extRst |=> s_r.cnt == '0) else $error("counter not reset");
  immediate_upd_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.ctl[BIT_IUE] |=> s_r.duty == $past(s_r.sDuty)) else $error("no immediate update");
  held_shadow_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_r.ctl[BIT_IUE] && !boundary) |=> $stable(s_r.duty) && $stable(s_r.ph))
    else $error("update off boundary");
  tb_select_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.ctl[BIT_ENABLE] && !s_r.ctl[BIT_TIME_BASE_SELECT] && !primaryTick && !extRst) |=> $stable(s_r.cnt))
    else $error("counter moved without tick");
  tb_second_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.ctl[BIT_ENABLE] && s_r.ctl[BIT_TIME_BASE_SELECT] && !secondaryTick && !extRst) |=> $stable(s_r.cnt))
    else $error("counter moved without secondary tick");

  // dead-time modes and compensation
  comp_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (dtc == DTC_COMP && s_r.ctl[BIT_COMPENSATION_POLARITY] && !cmpIn && s_r.ctl[BIT_ENABLE] && s_r.dly < s_r.dt)
    |=> (!s_r.lo && s_r.hi == $past(s_r.rawPwm)))
    else $error("low side not shortened");
  comp_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    (dtc == DTC_COMP && !s_r.ctl[BIT_COMPENSATION_POLARITY] && !cmpIn && s_r.ctl[BIT_ENABLE] && s_r.dly < s_r.dt)
    |=> (!s_r.hi && s_r.lo == !$past(s_r.rawPwm)))
    else $error("high side not shortened");
  comp_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    (dtc != DTC_COMP && dtc != DTC_NEG && s_r.ctl[BIT_ENABLE] &&
     s_r.dly >= s_r.dt && s_r.dly >= s_r.adt)
    |=> (s_r.hi == $past(s_r.rawPwm) && s_r.lo == !$past(s_r.rawPwm)))
    else $error("polarity acted outside compensation");
  neg_overlap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (dtc == DTC_NEG && s_r.ctl[BIT_ENABLE] && s_r.dly < s_r.dt) |=> (s_r.hi && s_r.lo))
    else $error("no negative dead time");
  off_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (dtc == DTC_OFF && s_r.ctl[BIT_ENABLE]) |=> (s_r.lo == !$past(s_r.rawPwm)))
    else $error("low side delayed with dead time off");

  // time base counting
  centre_down_a: assert property (@(posedge clk) disable iff (!rst_n)
    (centre && tick && s_r.ctl[BIT_ENABLE] && !extRst && s_r.down && s_r.cnt != '0)
    |=> (s_r.cnt == $past(s_r.cnt) - 1'b1))
    else $error("centre count not falling");
  centre_turn_a: assert property (@(posedge clk) disable iff (!rst_n)
    (centre && tick && s_r.ctl[BIT_ENABLE] && !extRst && !s_r.down && s_r.cnt >= s_r.per)
    |=> s_r.down)
    else $error("centre count did not turn");
  edge_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!centre && tick && s_r.ctl[BIT_ENABLE] && !extRst && s_r.cnt >= s_r.per) |=> (s_r.cnt == '0))
    else $error("edge count did not wrap");
  ext_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !s_r.ctl[BIT_EXTERNAL_PERIOD_RESET_ENABLE] |-> !extRst) else $error("reset without enable bit");

  // shadow registers
  boundary_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_r.ctl[BIT_IUE] && boundary)
    |=> (s_r.duty == $past(s_r.sDuty) && s_r.dt == $past(s_r.sDt) &&
         s_r.adt == $past(s_r.sAdt) && s_r.ph == $past(s_r.sPh)))
    else $error("shadows not copied at boundary");
  upd_all_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.ctl[BIT_IUE]
    |=> (s_r.dt == $past(s_r.sDt) && s_r.adt == $past(s_r.sAdt) && s_r.ph == $past(s_r.sPh)))
    else $error("timing words not immediate");

  // control register access
  ctl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.aPend && s_r.aWr && s_r.aAddr == OFS_CONTROL)
    |=> (!s_r.ctl[BIT_RSVD] && s_r.ctl[BIT_ENABLE] == $past(hwdata[BIT_ENABLE])))
    else $error("control write wrong");
  ctl_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.aPend && !s_r.aWr && s_r.aAddr == OFS_CONTROL) |-> !hrdata[BIT_RSVD])
    else $error("reserved bit read as one");

  centre_cv: cover property (@(posedge clk) centre && s_r.down);
  comp_cv: cover property (@(posedge clk) dtc == DTC_COMP && s_r.hi);
  ext_cv: cover property (@(posedge clk) extRst);
  neg_cv: cover property (@(posedge clk) dtc == DTC_NEG && s_r.hi && s_r.lo);
  upd_cv: cover property (@(posedge clk) !s_r.ctl[BIT_IUE] && boundary);
endmodule : pwm_generator_control_low_byte

// [verilog/pwm_gen_pkg.sv]
/*
  constants for the pwm generator control block: register map, field
  positions, reset values and dead-time modes.
  assumes a 32-bit AHB-Lite register bus, one word per register.
*/
package pwm_gen_pkg;
  localparam logic [7:0]  OFS_CONTROL   = 8'h00;
  localparam logic [7:0]  OFS_PERIOD    = 8'h04;
  localparam logic [7:0]  OFS_DUTY      = 8'h08;
  localparam logic [7:0]  OFS_DEADTIME  = 8'h0c;
  localparam logic [7:0]  OFS_ALTDEAD   = 8'h10;
  localparam logic [7:0]  OFS_PHASE     = 8'h14;
  localparam logic [7:0]  OFS_STATUS    = 8'h18;
  localparam int          BIT_IUE       = 0;
  localparam int          BIT_EXTERNAL_PERIOD_RESET_ENABLE     = 1;
  localparam int          BIT_CAM       = 2;
  localparam int          BIT_TIME_BASE_SELECT      = 3;
  localparam int          BIT_COMPENSATION_POLARITY      = 5;
  localparam int          BIT_DTC_LO    = 6;
  localparam int          BIT_ITB       = 8;
  localparam int          BIT_CURRENT_LIMIT_MODE     = 9;
  localparam int          BIT_ENABLE    = 15;
  localparam logic [15:0] CONTROL_WMASK = 16'h83ef;
  localparam logic [15:0] RESET_VALUE   = 16'h0000;
  localparam logic [1:0]  DTC_POS       = 2'h0;
  localparam logic [1:0]  DTC_NEG       = 2'h1;
  localparam logic [1:0]  DTC_OFF       = 2'h2;
  localparam logic [1:0]  DTC_COMP      = 2'h3;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage : pwm_gen_pkg

// [verification/power_stage_model.sv]
/*
  power stage model: tallies high-side on-time and shoot-through cycles.
  assumes gate drives are registered on clk and active high.
*/
`timescale 1ns/10ps
module power_stage_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // gate drives
  input  wire logic highSideOut,
  input  wire logic lowSideOut,
  // tallies
  output int        highCycles,
  output int        overlapCycles
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      highCycles    <= 0;
      overlapCycles <= 0;
    end else begin
      highCycles    <= highCycles + int'(highSideOut);
      // both switches on shorts the supply rail
      overlapCycles <= overlapCycles + int'(highSideOut && lowSideOut);
    end
  end
endmodule : power_stage_model

// [verification/tb_pwm_generator_control_low_byte.sv]
/*
  testbench for the pwm generator: register map, shadowed duty updates,
  time-base selection and gate overlap.
  assumes a zero-wait AHB-Lite slave and the power stage model beside it.
*/
`timescale 1ns/10ps
module tb_pwm_generator_control_low_byte;
  import pwm_gen_pkg::*;
  logic        clk, rst_n, hsel, hwrite, primaryTick, secondaryTick;
  logic        compensationPin, currentLimitPin, limOn, seenDown;
  logic [15:0] ctlNow;
  int          c1, ovBefore;
  logic [31:0] haddr, hwdata, rdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] seed = 32'h41;
  wire logic [31:0] hrdata;
  wire logic   hreadyout, hresp, highSideOut, lowSideOut;
  int          err_total = 0, num_checks = 0, highCycles, overlapCycles, activeDuty, shadowDuty;

  pwm_generator_control_low_byte dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .primaryTick(primaryTick),
    .secondaryTick(secondaryTick), .compensationPin(compensationPin),
    .currentLimitPin(currentLimitPin), .highSideOut(highSideOut), .lowSideOut(lowSideOut));
  power_stage_model stage (.clk(clk), .rst_n(rst_n), .highSideOut(highSideOut),
    .lowSideOut(lowSideOut), .highCycles(highCycles), .overlapCycles(overlapCycles));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // called just after a rising edge; waits on hready, never a fixed count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask : xfer

  // fields change only while the generator is disabled
  task automatic set_ctl(input logic [15:0] v);
    xfer(1'b1, OFS_CONTROL, {16'h0, ctlNow & 16'h7fff}, rdata);
    xfer(1'b1, OFS_CONTROL, {16'h0, v & 16'h7fff}, rdata);
    xfer(1'b1, OFS_CONTROL, {16'h0, v}, rdata);
    ctlNow = v;
  endtask : set_ctl

  task automatic two_counts(input string name);
    xfer(1'b0, OFS_STATUS, 32'h0, rdata);
    c1 = int'(rdata[15:0]);
    xfer(1'b0, OFS_STATUS, 32'h0, rdata);
    chk(name, 32'h1, {31'h0, (c1 != 0) || (rdata[15:0] != 16'h0)});
  endtask : two_counts

  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // pins wander at random; the limit pin can be held high for reset tests
  always @(posedge clk) begin
    seed            <= xs(seed);
    compensationPin <= seed[0];
    currentLimitPin <= limOn | seed[1];
  end

  initial begin
    #1_000_000;
    err_total++;
    wrap_up();
  end

  initial begin
    {rst_n, hwrite, htrans, haddr, hwdata, primaryTick, limOn} = '0;
    {hsel, secondaryTick} = 2'b11;
    hsize = 3'h2;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, OFS_CONTROL, 32'h0, rdata);
    chk("control", {16'h0, RESET_VALUE}, rdata);
    xfer(1'b1, OFS_CONTROL, 32'h7fff, rdata);
    xfer(1'b0, OFS_CONTROL, 32'h0, rdata);
    chk("control", {16'h0, CONTROL_WMASK & 16'h7fff}, rdata);
    xfer(1'b1, 8'h1c, 32'h5a, rdata);
    xfer(1'b0, 8'h1c, 32'h0, rdata);
    chk("unmapped", 32'h0, rdata);
    xfer(1'b1, OFS_PERIOD, 32'h8, rdata);
    xfer(1'b1, OFS_DEADTIME, 32'h2, rdata);
    activeDuty = 0;
    for (int i = 0; i < 4; i++) begin
      shadowDuty = 4 + int'(seed[1:0]);
      // update mode is chosen only while the generator is disabled
      xfer(1'b1, OFS_CONTROL, {31'h0, !i[0]}, rdata);
      xfer(1'b1, OFS_CONTROL, {31'h0, i[0]}, rdata);
      xfer(1'b1, OFS_CONTROL, {16'h0, 1'b1, 14'h0, i[0]}, rdata);
      xfer(1'b1, OFS_DUTY, 32'(shadowDuty), rdata);
      if (i[0]) activeDuty = shadowDuty;
      repeat (40) @(posedge clk);
      xfer(1'b0, OFS_DUTY, 32'h0, rdata);
      chk("duty", 32'(activeDuty), rdata);
      xfer(1'b1, OFS_CONTROL, {16'h0, 1'b1, 11'h0, 4'h8 | i[3:0] & 4'h1}, rdata);
      repeat (40) @(posedge clk);
      activeDuty = shadowDuty;
      xfer(0, OFS_DUTY, 32'h0, rdata);
      chk("duty", 32'(activeDuty), rdata);
    end
    chk("overlap", 32'h0, 32'(overlapCycles));
    chk("high on", 32'h1, {31'h0, highCycles > 0});
    ctlNow = 16'h8009;
    set_ctl(16'h800c);
    xfer(1'b0, OFS_STATUS, 32'h0, rdata);
    chk("centre", 32'h0, {31'h0, rdata[16]});
    set_ctl(16'h810c);
    seenDown = 1'b0;
    repeat (12) begin
      xfer(1'b0, OFS_STATUS, 32'h0, rdata);
      seenDown |= rdata[17];
    end
    chk("centre", 32'h1, {31'h0, rdata[16]});
    chk("centre down", 32'h1, {31'h0, seenDown});
    limOn <= 1'b1;
    set_ctl(16'h810a);
    repeat (6) @(posedge clk);
    xfer(1'b0, OFS_STATUS, 32'h0, rdata);
    chk("held count", 32'h0, {16'h0, rdata[15:0]});
    set_ctl(16'h830a);
    two_counts("limit mode count");
    set_ctl(16'h800a);
    two_counts("shared base count");
    limOn <= 1'b0;
    ovBefore = overlapCycles;
    set_ctl(16'h8048);
    repeat (40) @(posedge clk);
    chk("negative overlap", 32'h1, {31'h0, overlapCycles > ovBefore});
    set_ctl(16'h8088);
    repeat (4) @(posedge clk);
    repeat (16) begin
      @(posedge clk);
      chk("low side", {31'h0, !highSideOut}, {31'h0, lowSideOut});
    end
    ovBefore = overlapCycles;
    set_ctl(16'h80e8);
    repeat (40) @(posedge clk);
    chk("comp overlap", 32'(ovBefore), 32'(overlapCycles));
    wrap_up();
  end
endmodule : tb_pwm_generator_control_low_byte
